// ---- hdl/rfpo_output.sv ----
// Parallel host output logic of the read-only tag reader
`include "rfpo_consts.svh"

// Tick length is a parameter so a bench can shorten the millisecond
module rfpo_output #(
    parameter int TICK_CYCLES = `RFPO_TICK_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     trigger_mode,
    input  wire logic [15:0]              off_delay_ms,
    input  wire logic                     access_request_input,
    input  wire logic                     suppress_input,
    input  wire logic                     tag_present,
    input  wire rfpo_pkg::rfpo_access_type access_result,
    output logic                          access_start,
    output rfpo_pkg::rfpo_host_type       host_lines,
    output logic [15:0]                   data_led,
    output logic                          led_red,
    output logic                          error_led
);

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    logic [1:0] trg_sync_q;
    logic [1:0] sup_sync_q;
    logic       trg_q;
    logic       trg_rise;
    logic       sup;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trg_sync_q <= 2'h0;
            sup_sync_q <= 2'h0;
            trg_q      <= 1'b0;
        end else begin
            trg_sync_q <= {trg_sync_q[0], access_request_input};
            sup_sync_q <= {sup_sync_q[0], suppress_input};
            trg_q      <= trg_sync_q[1];
        end
    end

    assign trg_rise = trg_sync_q[1] & ~trg_q;
    assign sup      = sup_sync_q[1] & ~trigger_mode;

    // ***********************************************
    // Millisecond tick
    // ***********************************************
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    logic [15:0] tick_cnt_q;
    logic        ms_tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= 16'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h1;
        end
    end

    assign ms_tick = (tick_cnt_q == TICK_LAST); // [R22]

    function automatic logic odd_parity(input logic [15:0] w);
        odd_parity = ^w;
    endfunction

    // ***********************************************
    // Sequencer
    // ***********************************************
    rfpo_pkg::rfpo_state_type state_q;
    logic [15:0] ms_cnt_q;
    logic [15:0] word_q;
    logic        err_q;
    logic        left_q;
    logic        start_req;
    logic        lag_done;
    logic        off_done;

    // Presence mode requests a start whenever an unsuppressed tag is present; trigger mode only on a trigger edge
    assign start_req = trigger_mode ? trg_rise                        // [R18]
                                    : (tag_present & ~sup);           // [R2]
    assign lag_done  = ms_tick & (ms_cnt_q == 16'(`RFPO_STROBE_LAG_MS - 1));
    assign off_done  = ms_tick & (ms_cnt_q + 16'h1 >= off_delay_ms);
    // No request without a tag: a no-tag trigger is reported here, not by the front end
    assign access_start = start_req & tag_present & ((state_q == rfpo_pkg::RFPO_IDLE) |
                                       (state_q == rfpo_pkg::RFPO_OFFDLY) |
                                       (trigger_mode & (state_q != rfpo_pkg::RFPO_ACCESS)));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= rfpo_pkg::RFPO_IDLE;                          // [R1]
            ms_cnt_q <= 16'h0;
            word_q   <= `RFPO_WORD_RESET;
            err_q    <= 1'b0;
            left_q   <= 1'b0;
        end else if (sup) begin
            state_q  <= rfpo_pkg::RFPO_IDLE;                          // [R7]
            ms_cnt_q <= 16'h0;
            err_q    <= 1'b0;
        end else if (trigger_mode & trg_rise & ~tag_present &
                     (state_q != rfpo_pkg::RFPO_ACCESS)) begin
            // No tag at the trigger: report at once, off-delay runs from the end of the lag
            state_q  <= rfpo_pkg::RFPO_LAG;                           // [R20]
            word_q   <= `RFPO_ERR_NOTAG_CODE;
            err_q    <= 1'b1;
            left_q   <= 1'b1;
            ms_cnt_q <= 16'h0;
        end else if (access_start) begin
            state_q  <= rfpo_pkg::RFPO_ACCESS;                        // [R8] [R21]
            ms_cnt_q <= 16'h0;
            err_q    <= 1'b0;
            left_q   <= 1'b0;
        end else begin
            case (state_q)
                rfpo_pkg::RFPO_IDLE: begin
                    ms_cnt_q <= 16'h0;
                end
                rfpo_pkg::RFPO_ACCESS: begin
                    if (~tag_present) begin
                        left_q <= 1'b1;
                    end
                    if (access_result.done) begin
                        state_q  <= rfpo_pkg::RFPO_LAG;
                        ms_cnt_q <= 16'h0;
                        if (!access_result.ok || left_q || !tag_present) begin
                            word_q <= `RFPO_ERR_LEFT_CODE;            // [R10] [R20]
                            err_q  <= 1'b1;
                            left_q <= 1'b1;
                        end else begin
                            word_q <= access_result.word;             // [R2]
                        end
                    end
                end
                rfpo_pkg::RFPO_LAG: begin
                    if (~tag_present) begin
                        left_q <= 1'b1;
                    end
                    if (ms_tick) begin
                        ms_cnt_q <= ms_cnt_q + 16'h1;
                    end
                    if (lag_done) begin
                        state_q  <= rfpo_pkg::RFPO_HOLD;              // [R4] [R12]
                        ms_cnt_q <= 16'h0;
                    end
                end
                rfpo_pkg::RFPO_HOLD: begin
                    // Tag that left mid-access times its off-delay from the end of the lag
                    if (~tag_present | left_q) begin
                        state_q  <= rfpo_pkg::RFPO_OFFDLY;            // [R6] [R12]
                        ms_cnt_q <= 16'h0;
                    end
                end
                rfpo_pkg::RFPO_OFFDLY: begin
                    if (ms_tick) begin
                        ms_cnt_q <= ms_cnt_q + 16'h1;
                    end
                    if (off_done) begin
                        state_q <= rfpo_pkg::RFPO_IDLE;               // [R6] [R13]
                        err_q   <= 1'b0;
                    end
                end
                default: begin
                    state_q <= rfpo_pkg::RFPO_IDLE;
                end
            endcase
        end
    end

    // ***********************************************
    // Host lines
    // ***********************************************
    logic presenting;
    logic strobe_phase;

    assign presenting   = (state_q == rfpo_pkg::RFPO_LAG) |
                          (state_q == rfpo_pkg::RFPO_HOLD) |
                          (state_q == rfpo_pkg::RFPO_OFFDLY);
    assign strobe_phase = (state_q == rfpo_pkg::RFPO_HOLD) |
                          (state_q == rfpo_pkg::RFPO_OFFDLY);

    // Registered outputs; held unchanged across HOLD while the tag stays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_lines <= '0;                                         // [R1] [R14]
        end else if (sup || !presenting || access_start) begin
            host_lines <= '0;                                         // [R7] [R8]
        end else begin
            host_lines.read_word_lines        <= word_q;              // [R5]
            host_lines.parity                 <= odd_parity(word_q);  // [R3] [R11]
            host_lines.normal_complete_strobe <= strobe_phase & ~err_q; // [R4]
            host_lines.error                  <= strobe_phase & err_q;  // [R12] [R14]
        end
    end

    // ***********************************************
    // Indicators
    // ***********************************************
    localparam logic [15:0] FLASH_LAST = 16'(`RFPO_FLASH_HALF_MS - 1);
    logic [15:0] flash_cnt_q;
    logic        flash_q;
    logic        led_err_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_q <= 16'h0;
            flash_q     <= 1'b0;
        end else if (ms_tick) begin
            if (flash_cnt_q == FLASH_LAST) begin
                flash_cnt_q <= 16'h0;
                flash_q     <= ~flash_q;
            end else begin
                flash_cnt_q <= flash_cnt_q + 16'h1;
            end
        end
    end

    // Pattern survives the off-delay; only a new access, a trigger edge in trigger mode or suppress replaces it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_led  <= 16'h0;
            led_err_q <= 1'b0;
        end else if (sup || access_start || (trigger_mode && trg_rise)) begin
            data_led  <= 16'h0;                                       // [R9] [R21]
            led_err_q <= 1'b0;
        end else if (state_q == rfpo_pkg::RFPO_LAG && ms_cnt_q == 16'h0) begin
            data_led  <= word_q;                                      // [R9]
            led_err_q <= err_q;
        end else if (led_err_q) begin
            data_led  <= flash_q ? word_q : 16'h0;                    // [R10]
        end
    end

    assign led_red   = led_err_q;
    assign error_led = led_err_q;

endmodule

// ---- shared/rfpo_consts.svh ----
// Timing, code and reset constants of the tag-reader parallel output block
// Functional notes
// [R1] After reset all sixteen data lines are low; presence mode waits for a tag.
// [R2] Presence mode reads a tag on entry, presents the word, lights indicators.
// [R3] Parity line is high when an odd number of data lines are high.
// [R4] Normal-complete strobe rises 3 ms after the read word appears.
// [R5] Data, parity and strobe hold while the tag stays in the area.
// [R6] Tag leaving starts a selectable off-delay; expiry drives all lines low.
// [R7] Suppress in presence mode forces data, parity, strobe and error low at once.
// [R8] A new access during the off-delay clears outputs before presenting results.
// [R9] Indicators keep their pattern until the next access; suppress blanks them.
// [R10] Tag leaving mid-access is an error: error code on lines, flashed in red.
// [R11] The single error-code bit makes the parity line high.
// [R12] Error line rises 3 ms after the code; held until off-delay expires.
// [R13] Off-delay expiry after an error drops data, parity and error together.
// [R14] Error line low doubles as a running indication.
// [R15] Host holds suppress asserted for at least 20 ms.
// [R16] Host captures data only on the rising normal-complete strobe.
// [R17] Host should suppress once data is fetched from a stationary tag.
// [R18] Trigger mode reads only on trigger, then behaves like presence mode.
// [R19] Host holds the trigger asserted for at least 10 ms.
// [R20] Trigger mode flags no-tag and tag-left errors with code, parity, error line.
// [R21] In trigger mode a trigger after an error clears all lines and indicators.
// [R22] All millisecond delays count a millisecond tick from the system clock.
`ifndef RFPO_CONSTS_SVH
`define RFPO_CONSTS_SVH
`define RFPO_CLK_HZ         40000000
`define RFPO_TICK_MS        1
`define RFPO_TICK_CYCLES    (`RFPO_CLK_HZ / 1000 * `RFPO_TICK_MS)
`define RFPO_STROBE_LAG_MS  3
`define RFPO_FLASH_HALF_MS  250
`define RFPO_ERR_LEFT_CODE  16'h0001
`define RFPO_ERR_NOTAG_CODE 16'h0002
`define RFPO_WORD_RESET     16'h0000
`endif

// ---- shared/rfpo_pkg.sv ----
// Types of the tag-reader parallel output block
package rfpo_pkg;
    typedef enum logic [2:0] {
        RFPO_IDLE    = 3'b000,
        RFPO_ACCESS  = 3'b001,
        RFPO_LAG     = 3'b010,
        RFPO_HOLD    = 3'b011,
        RFPO_OFFDLY  = 3'b100
    } rfpo_state_type;

    // Result of one tag access from the radio front end
    typedef struct packed {
        logic        done;
        logic        ok;
        logic [15:0] word;
    } rfpo_access_type;

    // Lines seen by the host controller
    typedef struct packed {
        logic [15:0] read_word_lines;
        logic        parity;
        logic        normal_complete_strobe;
        logic        error;
    } rfpo_host_type;
endpackage

// ---- bench/rfpo_output_sva.sv ----
// Port checker of the tag-reader parallel output block
`include "rfpo_consts.svh"
module rfpo_output_sva #(
    parameter int TICK_CYCLES = `RFPO_TICK_CYCLES
) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      trigger_mode,
    input wire logic                      suppress_input,
    input wire logic                      tag_present,
    input wire rfpo_pkg::rfpo_access_type access_result,
    input wire rfpo_pkg::rfpo_host_type   host_lines,
    input wire logic [15:0]               data_led
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAG_MIN = 2 * TICK_CYCLES - 4;
    localparam int LAG_MAX = 3 * TICK_CYCLES + 4;
    logic [15:0] word_q;
    logic [16:0] since_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Age of the word; saturates so a long hold never wraps back into the lag window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q  <= '0;
            since_q <= '0;
        end else begin
            word_q  <= host_lines.read_word_lines;
            if (host_lines.read_word_lines != word_q) since_q <= '0;
            else if (!(&since_q)) since_q <= since_q + 17'h1;
        end
    end
    property p_parity; host_lines.parity == ^host_lines.read_word_lines; endproperty
    a_parity: assert property (p_parity) else $error("parity wrong");
    property p_word; access_result.done && access_result.ok && tag_present && !suppress_input
        |-> ##2 host_lines.read_word_lines == $past(access_result.word, 2); endproperty
    a_word: assert property (p_word) else $error("word not shown");
    property p_left; access_result.done && !access_result.ok
        |-> ##2 host_lines.read_word_lines == `RFPO_ERR_LEFT_CODE; endproperty
    a_left: assert property (p_left) else $error("no left code");
    property p_strobe_lag; $rose(host_lines.normal_complete_strobe)
        |-> since_q inside {[LAG_MIN:LAG_MAX]}; endproperty
    a_strobe_lag: assert property (p_strobe_lag) else $error("strobe lag");
    property p_err_lag; $rose(host_lines.error) |-> since_q inside {[LAG_MIN:LAG_MAX]}; endproperty
    a_err_lag: assert property (p_err_lag) else $error("error lag");
    property p_hold; (tag_present && !suppress_input && !trigger_mode
        && host_lines.normal_complete_strobe) [*4] |=> $stable(host_lines); endproperty
    a_hold: assert property (p_hold) else $error("lines moved");
    property p_suppress; (suppress_input && !trigger_mode) [*4]
        |-> host_lines == '0 && data_led == '0; endproperty
    a_suppress: assert property (p_suppress) else $error("not suppressed");
    property p_drop; $fell(host_lines.normal_complete_strobe) || $fell(host_lines.error)
        |-> host_lines.read_word_lines == '0 && !host_lines.parity; endproperty
    a_drop: assert property (p_drop) else $error("lines not dropped together");
endmodule
bind rfpo_output rfpo_output_sva #(.TICK_CYCLES(TICK_CYCLES)) rfpo_output_sva_i (.clk(clk),
    .rst_n(rst_n),
    .trigger_mode(trigger_mode), .suppress_input(suppress_input), .tag_present(tag_present),
    .access_result(access_result), .host_lines(host_lines), .data_led(data_led));

// ---- bench/rfpo_frontend_model.sv ----
// Radio front-end model answering each access after a set latency
module rfpo_frontend_model (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                access_start,
    input  wire logic                tag_present,
    input  wire logic [15:0]         tag_word,
    input  wire logic [15:0]         latency,
    output rfpo_pkg::rfpo_access_type access_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        busy_q;
    logic        lost_q;
    logic [15:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {busy_q, lost_q, cnt_q} <= '0;
            access_result <= '0;
        end else begin
            // Word bus toggles when no answer is due, so a stale value cannot pass
            access_result <= {2'b00, ~access_result.word};
            if (access_start) begin
                {busy_q, lost_q, cnt_q} <= {1'b1, !tag_present, latency};
            end else if (busy_q) begin
                lost_q <= lost_q | !tag_present;
                cnt_q  <= cnt_q - 16'h1;
                if (cnt_q == 16'h0) begin
                    busy_q        <= 1'b0;
                    access_result <= {1'b1, !(lost_q | !tag_present), tag_word};
                end
            end
        end
    end
endmodule

// ---- bench/tb_rfid_read_parallel_output.sv ----
// Self-checking bench of the tag-reader parallel output block
`include "rfpo_consts.svh"
module tb_rfid_read_parallel_output;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened millisecond keeps the run to a few thousand cycles
    localparam int TICK = 40;
    logic clk, rst_n, trigger_mode, access_request_input, suppress_input, tag_present;
    logic access_start, led_red, error_led;
    logic [15:0] off_delay_ms, tag_word, latency, data_led, w;
    rfpo_pkg::rfpo_access_type access_result;
    rfpo_pkg::rfpo_host_type   host_lines;
    int miscompares, compares, waited;
    logic [31:0] seed = 32'h6425b545;
    rfpo_output #(.TICK_CYCLES(TICK)) rfpo_output_i (.clk(clk), .rst_n(rst_n),
        .trigger_mode(trigger_mode),
        .off_delay_ms(off_delay_ms), .access_request_input(access_request_input),
        .suppress_input(suppress_input), .tag_present(tag_present),
        .access_result(access_result), .access_start(access_start), .host_lines(host_lines),
        .data_led(data_led), .led_red(led_red), .error_led(error_led));
    rfpo_frontend_model rfpo_frontend_model_i (.clk(clk), .rst_n(rst_n),
        .access_start(access_start), .tag_present(tag_present), .tag_word(tag_word),
        .latency(latency), .access_result(access_result));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [18:0] lines_of(logic [15:0] v, logic err);
        return {v, ^v, !err, err};
    endfunction
    task automatic check(logic [18:0] got, logic [18:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait: 0 strobe high, 1 error high, 2 all lines low
    task automatic wait_for(int what);
        waited = 0;
        while (waited < 10 * TICK && !(what == 0 ? host_lines.normal_complete_strobe === 1'b1 :
               what == 1 ? host_lines.error === 1'b1 : host_lines === '0)) begin
            step(1);
            waited++;
        end
    endtask
    // Trigger stays up its full minimum time even after the answer shows
    task automatic trigger_read(int what, logic [18:0] exp);
        access_request_input = 1'b1;
        wait_for(what);
        check(host_lines, exp);
        step(10 * TICK - waited);
        access_request_input = 1'b0;
        step(2);
    endtask
    task automatic conclude();
        $display("compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #1_000_000;
        miscompares++;
        conclude();
    end
    initial begin
        {rst_n, trigger_mode, access_request_input, suppress_input, tag_present} = '0;
        {tag_word, latency, miscompares, compares} = '0;
        // Off-delay above the strobe lag, so an error is seen before it expires
        off_delay_ms = 16'h0005;
        step(4);
        rst_n = 1'b1;
        check(host_lines, '0);
        for (int i = 0; i < 4; i++) begin
            w = i == 0 ? 16'hffff : i == 1 ? 16'h8000 : 16'(xs()) | 16'h0100;
            tag_word = w;
            latency = 16'(xs() % 64);
            tag_present = 1'b1;
            wait_for(0);
            check(host_lines, lines_of(w, 1'b0));
            check(19'(data_led), 19'(w));
            step(100);
            check(host_lines, lines_of(w, 1'b0));
            tag_present = 1'b0;
            wait_for(2);
            check(19'(waited >= 4 * TICK && waited <= 5 * TICK + 10), 19'h1);
        end
        tag_present = 1'b1;
        wait_for(0);
        suppress_input = 1'b1;
        step(4);
        check(host_lines, '0);
        check(19'(data_led), 19'h0);
        step(20 * TICK);
        {tag_present, suppress_input} = '0;
        step(TICK);
        latency = 16'h0080;
        tag_present = 1'b1;
        step(20);
        tag_present = 1'b0;
        wait_for(1);
        check(host_lines, lines_of(`RFPO_ERR_LEFT_CODE, 1'b1));
        check(19'(error_led), 19'h1);
        check(19'(led_red), 19'h1);
        wait_for(2);
        check(host_lines, '0);
        rst_n = 1'b0;
        trigger_mode = 1'b1;
        latency = 16'h0010;
        step(4);
        rst_n = 1'b1;
        step(4);
        trigger_read(1, lines_of(`RFPO_ERR_NOTAG_CODE, 1'b1));
        tag_word = 16'(xs()) | 16'h0010;
        tag_present = 1'b1;
        trigger_read(0, lines_of(tag_word, 1'b0));
        tag_present = 1'b0;
        wait_for(2);
        check(host_lines, '0);
        conclude();
    end
endmodule
